//--- rtl/serial_char_unit.sv
// serial character unit: clocked-mode receiver with holding register and
// status, five parity kinds plus multidrop, transmit guard gap, idle time-out.
// assumes baudClk and rxdIn are synchronous to clk_sys; one baud rising edge
// is one bit period for both directions.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module serial_char_unit (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] wbAdr, // wishbone byte address
  input wire logic [31:0] wbDatW, // wishbone write data
  input wire logic [3:0] wbSel, // wishbone byte selects
  input wire logic wbWe, // wishbone write enable
  input wire logic wbCyc, // wishbone cycle
  input wire logic wbStb, // wishbone strobe
  output logic wbAck, // wishbone acknowledge
  output logic [31:0] wbDatR, // wishbone read data
  input wire logic baudClk, // baud-rate clock level
  input wire logic rxdIn, // serial receive line
  output logic txdOut, // serial transmit line
  output logic timeoutIrq // interrupt request on receiver time-out
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire logic access = wbCyc & wbStb & ~wbAck; // one ack per request
  wire logic wrLow = access & wbWe & wbSel[0];
  wire logic wrHigh = access & wbWe & wbSel[1];
  wire logic wrCmd = wrLow && (wbAdr == serial_char_pkg::OFS_COMMAND);
  wire logic wrMode = wrLow && (wbAdr == serial_char_pkg::OFS_MODE);
  wire logic wrThr = wrLow && (wbAdr == serial_char_pkg::OFS_TX_HOLD);
  wire logic wrGuard = wrLow && (wbAdr == serial_char_pkg::OFS_GUARD);
  wire logic wrIdleLo = wrLow && (wbAdr == serial_char_pkg::OFS_IDLE);
  wire logic wrIdleHi = wrHigh && (wbAdr == serial_char_pkg::OFS_IDLE);
  wire logic rdRhr = access && !wbWe && (wbAdr == serial_char_pkg::OFS_RX_HOLD);
  wire logic cmdClear = wrCmd & wbDatW[serial_char_pkg::CMD_CLEAR_STATUS];
  wire logic cmdMark = wrCmd & wbDatW[serial_char_pkg::CMD_MARK_ADDR];
  wire logic cmdArm = wrCmd & wbDatW[serial_char_pkg::CMD_ARM_IDLE];
  wire logic cmdRestart = wrCmd & wbDatW[serial_char_pkg::CMD_RESTART_IDLE];

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [2:0] checkBitKind; // check_bit_kind
  logic [serial_char_pkg::GUARD_W-1:0] guardGapLen; // guard_gap_len, 8 bits
  logic [serial_char_pkg::IDLE_W-1:0] idleLimitValue; // idle_limit_value

  // software-written fields, byte lanes honoured
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      checkBitKind <= serial_char_pkg::KIND_RESET;
      guardGapLen <= '0;
      idleLimitValue <= '0;
    end else begin
      if (wrMode) checkBitKind <= wbDatW[serial_char_pkg::KIND_LSB +: serial_char_pkg::KIND_W];
      if (wrGuard) guardGapLen <= wbDatW[7:0]; // RULE24
      if (wrIdleLo) idleLimitValue[7:0] <= wbDatW[7:0];
      if (wrIdleHi) idleLimitValue[15:8] <= wbDatW[15:8];
    end
  end

  // ------------------------------------------------------------
  // parity helpers
  // ------------------------------------------------------------
  // multidrop when kind is 6 or 7, parity off when kind is 4 or 5
  wire logic multidrop = (checkBitKind[2:1] == 2'b11); // RULE12
  wire logic parityOff = (checkBitKind[2:1] == 2'b10); // RULE10

  // parity bit the transmitter sends for a byte; addrMark only counts in multidrop
  function automatic logic parity_of(input logic [2:0] kind, input logic [7:0] data, input logic addrMark);
    logic bitVal;
    bitVal = 1'b0;
    unique case (kind)
      serial_char_pkg::KIND_EVEN: bitVal = ^data; // RULE6
      serial_char_pkg::KIND_ODD: bitVal = ~(^data); // RULE7
      serial_char_pkg::KIND_SPACE: bitVal = 1'b0; // RULE9
      serial_char_pkg::KIND_MARK: bitVal = 1'b1; // RULE8
      3'h6, 3'h7: bitVal = addrMark; // RULE14
      default: bitVal = 1'b0;
    endcase
    return bitVal;
  endfunction : parity_of

  // ------------------------------------------------------------
  // baud edge detect
  // ------------------------------------------------------------
  logic baudPrev; // last sampled baud level
  wire logic baudRise = baudClk & ~baudPrev; // one bit period boundary

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) baudPrev <= 1'b0;
    else baudPrev <= baudClk;
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  typedef enum logic [1:0] {RX_WAIT, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
  rx_state_t rxState;
  logic [2:0] rxCount; // data bit index
  logic [7:0] rxShift; // lsb first assembly
  logic rxParBit; // sampled parity bit
  logic [7:0] receiveHoldingReg; // receive_holding_reg
  logic rxCharAvail; // rx_char_avail
  logic rxOverrunFlag; // rx_overrun_flag
  logic checkBitError; // check_bit_error

  // a character completes at the stop-bit sample; stop level is not judged here
  wire logic rxDone = baudRise && (rxState == RX_STOP);
  // expected parity compared with the sampled one; multidrop flags any high bit
  wire logic rxParBad = multidrop ? rxParBit : // RULE13
                        (!parityOff && (rxParBit != parity_of(checkBitKind, rxShift, 1'b0))); // RULE6 RULE7 RULE8 RULE9 RULE10

  // bit-level receive sequence, advanced on baud rising edges only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxState <= RX_WAIT;
      rxCount <= '0;
      rxShift <= '0;
      rxParBit <= 1'b0;
    end else if (baudRise) begin
      unique case (rxState)
        RX_WAIT: begin
          if (!rxdIn) rxState <= RX_DATA; // RULE1
          rxCount <= '0;
        end
        RX_DATA: begin
          rxShift <= {rxdIn, rxShift[7:1]};
          rxCount <= rxCount + 3'h1;
          if (rxCount == 3'h7) rxState <= parityOff ? RX_STOP : RX_PAR; // RULE2
        end
        RX_PAR: begin
          rxParBit <= rxdIn;
          rxState <= RX_STOP;
        end
        RX_STOP: rxState <= RX_WAIT; // RULE2
      endcase
    end
  end

  // holding register and receive flags; a set always beats a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      receiveHoldingReg <= '0;
      rxCharAvail <= 1'b0;
      rxOverrunFlag <= 1'b0;
      checkBitError <= 1'b0;
    end else begin
      if (rxDone) receiveHoldingReg <= rxShift; // RULE3 RULE4
      if (rxDone) rxCharAvail <= 1'b1; // RULE3
      else if (rdRhr) rxCharAvail <= 1'b0;
      if (rxDone && rxCharAvail) rxOverrunFlag <= 1'b1; // RULE4
      else if (cmdClear) rxOverrunFlag <= 1'b0; // RULE5
      if (rxDone && rxParBad) checkBitError <= 1'b1; // RULE11
      else if (cmdClear) checkBitError <= 1'b0; // RULE11
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_GUARD} tx_state_t;
  tx_state_t txState;
  logic [7:0] transmitHoldingReg; // transmit_holding_reg
  logic thrFull; // a byte waits in the holding register
  logic thrAddr; // waiting byte goes out as an address
  logic markPending; // address command seen, next write takes it
  logic [7:0] txShift; // byte being sent
  logic txParBit; // parity bit for the byte being sent
  logic [2:0] txCount; // data bit index
  logic [serial_char_pkg::GUARD_W-1:0] guardLeft; // guard periods still to send

  // the holding register drains only as a start bit goes out
  wire logic txAtEnd = (txState == TX_IDLE) || (txState == TX_GUARD && guardLeft == '0);
  wire logic txLoad = baudRise && txAtEnd && thrFull; // RULE16

  // holding register, write side and drain side
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transmitHoldingReg <= '0;
      thrFull <= 1'b0;
      thrAddr <= 1'b0;
      markPending <= 1'b0;
    end else begin
      if (wrThr) begin
        transmitHoldingReg <= wbDatW[7:0];
        thrAddr <= markPending | cmdMark; // RULE14
      end
      // a write while full overwrites; software is expected to poll the free flag
      if (wrThr) thrFull <= 1'b1;
      else if (txLoad) thrFull <= 1'b0; // RULE16
      if (wrThr) markPending <= 1'b0;
      else if (cmdMark) markPending <= 1'b1; // RULE14
    end
  end

  // bit-level transmit sequence
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txState <= TX_IDLE;
      txShift <= '0;
      txParBit <= 1'b0;
      txCount <= '0;
      guardLeft <= '0;
      txdOut <= 1'b1;
    end else if (baudRise) begin
      unique case (txState)
        TX_START: begin
          txdOut <= txShift[0];
          txShift <= {1'b0, txShift[7:1]};
          txCount <= '0;
          txState <= TX_DATA;
        end
        TX_DATA: begin
          txCount <= txCount + 3'h1;
          if (txCount == 3'h7) begin
            txdOut <= parityOff ? 1'b1 : txParBit; // RULE10
            // the stop bit is spent in the guard state before the gap counts down
            guardLeft <= guardGapLen; // RULE15
            txState <= parityOff ? TX_GUARD : TX_PAR;
          end else begin
            txdOut <= txShift[0];
            txShift <= {1'b0, txShift[7:1]};
          end
        end
        TX_PAR: begin
          txdOut <= 1'b1;
          txState <= TX_GUARD;
        end
        TX_IDLE, TX_GUARD: begin
          if (txState == TX_GUARD && guardLeft != '0) begin
            guardLeft <= guardLeft - 8'h01; // RULE15
            txdOut <= 1'b1;
          end else if (thrFull) begin
            txdOut <= 1'b0; // start bit
            txShift <= transmitHoldingReg;
            txParBit <= parity_of(checkBitKind, transmitHoldingReg, thrAddr); // RULE6 RULE7 RULE8 RULE9 RULE14
            txState <= TX_START;
          end else begin
            txdOut <= 1'b1;
            txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // the guard gap belongs to the character, so idle waits for its end
  wire logic txAllIdle = (txState == TX_IDLE) && !thrFull; // RULE17

  // ------------------------------------------------------------
  // receiver idle time-out
  // ------------------------------------------------------------
  logic [serial_char_pkg::IDLE_W-1:0] idleCount; // 16-bit down-counter
  logic idleRun; // counter clock running
  logic idleTimeout; // time-out flag
  wire logic idleOn = (idleLimitValue != '0); // RULE18

  // count per bit period, reload per character, flag at zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idleCount <= '0;
      idleRun <= 1'b0;
      idleTimeout <= 1'b0;
    end else begin
      if (!idleOn) begin
        idleRun <= 1'b0;
        idleTimeout <= 1'b0; // RULE18
      end else if (cmdRestart) begin
        idleCount <= idleLimitValue; // RULE21
        idleRun <= 1'b1;
        idleTimeout <= 1'b0; // RULE23
      end else if (cmdArm) begin
        idleRun <= 1'b0; // RULE20
        idleTimeout <= 1'b0; // RULE23
      end else if (rxDone) begin
        idleCount <= idleLimitValue; // RULE19
        idleRun <= 1'b1;
      end else if (idleRun && baudRise) begin
        if (idleCount == 16'h0001 || idleCount == '0) begin
          idleCount <= '0;
          idleRun <= 1'b0;
          idleTimeout <= 1'b1; // RULE19
        end else begin
          idleCount <= idleCount - 16'h0001; // RULE19
        end
      end
    end
  end

  // ------------------------------------------------------------
  // status word and bus answer
  // ------------------------------------------------------------
  wire logic [31:0] statusWord = {26'h0, idleTimeout, txAllIdle, checkBitError,
                                  rxOverrunFlag, !thrFull, rxCharAvail};
  wire logic [31:0] readMux =
    (wbAdr == serial_char_pkg::OFS_MODE) ? {29'h0, checkBitKind} :
    (wbAdr == serial_char_pkg::OFS_STATUS) ? statusWord :
    (wbAdr == serial_char_pkg::OFS_RX_HOLD) ? {24'h0, receiveHoldingReg} :
    (wbAdr == serial_char_pkg::OFS_GUARD) ? {24'h0, guardGapLen} :
    (wbAdr == serial_char_pkg::OFS_IDLE) ? {16'h0, idleLimitValue} : 32'h0;

  // every address acks; unmapped ones read zero and ignore writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatR <= '0;
      timeoutIrq <= 1'b0;
    end else begin
      wbAck <= access;
      wbDatR <= access ? readMux : 32'h0;
      timeoutIrq <= idleTimeout; // RULE22
    end
  end
endmodule : serial_char_unit
`default_nettype wire

//--- common/serial_char_pkg.sv
// constants shared by the serial character unit: register map, field layout,
// command bits, status bits and parity kind codes.
// assumes a 32-bit classic wishbone slave with byte addressing.
// Notes on behaviour
// RULE1: clocked mode: low sample on baud edge starts
// RULE2: sample data, parity, stop; then await start
// RULE3: completed char to holding reg, raise avail
// RULE4: completion while avail set: overrun, overwrite
// RULE5: clear-status command clears overrun
// RULE6: even parity generate and check
// RULE7: odd parity generate and check
// RULE8: mark parity sends 1, 0 errors
// RULE9: space parity sends 0, 1 errors
// RULE10: parity off: no bit, no error
// RULE11: parity error flag, cleared by clear-status
// RULE12: kind 6 or 7 selects multidrop
// RULE13: multidrop receive: high parity sets error
// RULE14: address command marks next written byte
// RULE15: guard length adds idle bit periods
// RULE16: holding-free rises at next start bit
// RULE17: all-idle stays low through guard gap
// RULE18: idle limit zero disables time-out
// RULE19: 16-bit down-counter per bit, reload, flag
// RULE20: arm command stops counter until character
// RULE21: restart command counts from limit immediately
// RULE22: time-out flag drives interrupt request
// RULE23: arm or restart clears pending time-out
// RULE24: guard length field is eight bits
package serial_char_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND = 8'h00; // command_reg, write only
  localparam logic [7:0] OFS_MODE = 8'h04; // mode_config_reg
  localparam logic [7:0] OFS_STATUS = 8'h08; // channel_status_reg, read only
  localparam logic [7:0] OFS_RX_HOLD = 8'h0c; // receive_holding_reg
  localparam logic [7:0] OFS_TX_HOLD = 8'h10; // transmit_holding_reg
  localparam logic [7:0] OFS_GUARD = 8'h14; // guard_gap_reg
  localparam logic [7:0] OFS_IDLE = 8'h18; // idle_limit_reg
  // ------------------------------------------------------------
  // command bits
  // ------------------------------------------------------------
  localparam int CMD_CLEAR_STATUS = 0; // clear_status_cmd
  localparam int CMD_MARK_ADDR = 1; // mark_next_address_cmd
  localparam int CMD_ARM_IDLE = 2; // arm_idle_on_next_char_cmd
  localparam int CMD_RESTART_IDLE = 3; // restart_idle_count_cmd
  // ------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------
  localparam int ST_RX_AVAIL = 0; // rx_char_avail
  localparam int ST_TX_FREE = 1; // tx_holding_free
  localparam int ST_OVERRUN = 2; // rx_overrun_flag
  localparam int ST_CHECK_ERR = 3; // check_bit_error
  localparam int ST_TX_IDLE = 4; // tx_all_idle
  localparam int ST_TIMEOUT = 5; // receiver time-out
  // ------------------------------------------------------------
  // mode field layout and check_bit_kind codes
  // ------------------------------------------------------------
  localparam int KIND_LSB = 0;
  localparam int KIND_W = 3;
  localparam logic [2:0] KIND_EVEN = 3'h0;
  localparam logic [2:0] KIND_ODD = 3'h1;
  localparam logic [2:0] KIND_SPACE = 3'h2;
  localparam logic [2:0] KIND_MARK = 3'h3;
  localparam logic [2:0] KIND_RESET = 3'h4; // parity off after reset
  localparam int GUARD_W = 8; // guard_gap_len width
  localparam int IDLE_W = 16; // idle_limit_value width
  localparam int DATA_W = 8; // character width
endpackage : serial_char_pkg

//--- test/serial_char_props.sv
// port checker for the serial character unit
// assumes one clock domain and a master that waits for ack
`timescale 1ns/1ns
`default_nettype none
module serial_char_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [3:0] wbSel,
  input wire logic wbWe,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic [31:0] wbDatR,
  input wire logic baudClk,
  input wire logic rxdIn,
  input wire logic txdOut,
  input wire logic timeoutIrq
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic limZ; // idle limit currently zero
  logic bPrev; // baud level one clock ago
  logic [3:0] since; // clocks since the last baud rise, saturating
  wire logic take = wbCyc && wbStb && !wbAck; // request taken at this edge
  wire logic rdSt = take && !wbWe && wbAdr == serial_char_pkg::OFS_STATUS;
  wire logic cmdW = take && wbWe && wbAdr == serial_char_pkg::OFS_COMMAND;
  wire logic idleW = take && wbWe && wbAdr == serial_char_pkg::OFS_IDLE;
  wire logic bRise = baudClk && !bPrev;
  wire logic [3:0] next_since = bRise ? 4'h0 : (since == 4'hf ? since : since + 4'h1);
  // a rise seen later than a few clocks would hide a slow bit boundary
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      limZ <= 1'b1;
      bPrev <= 1'b0;
      since <= 4'hf;
    end else begin
      limZ <= idleW ? (wbDatW[15:0] == 16'h0) : limZ;
      bPrev <= baudClk;
      since <= next_since;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  ack_one_cycle_a: assert property (take |=> wbAck) else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wbAck |-> $past(take)) else $error("ack without request");
  data_idle_a: assert property (!wbAck |-> wbDatR == 32'h0) else $error("read data not zero when idle");
  cmd_read_zero_a: assert property (take && !wbWe && wbAdr == serial_char_pkg::OFS_COMMAND |=> wbDatR == 32'h0)
    else $error("command register read not zero");
  irq_copy_a: assert property (rdSt |=> wbDatR[serial_char_pkg::ST_TIMEOUT] == timeoutIrq)
    else $error("interrupt differs from time-out flag");
  txd_bit_edge_a: assert property ($changed(txdOut) |-> since <= 4'h3)
    else $error("transmit line moved off a bit boundary");
  idle_off_a: assert property (limZ && $past(limZ) && $past(limZ, 2) |-> !timeoutIrq)
    else $error("time-out raised with zero idle limit");
  arm_clear_a: assert property (cmdW && (wbDatW[2] || wbDatW[3]) |-> ##[1:3] !timeoutIrq)
    else $error("time-out not cleared by arm or restart");
  cover property (take && wbWe);
  cover property ($rose(timeoutIrq));
  cover property ($fell(txdOut));
endmodule : serial_char_props
bind serial_char_unit serial_char_props chk_u (.clk_sys(clk_sys), .rst(rst), .wbAdr(wbAdr), .wbDatW(wbDatW),
  .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbDatR(wbDatR),
  .baudClk(baudClk), .rxdIn(rxdIn), .txdOut(txdOut), .timeoutIrq(timeoutIrq));
`default_nettype wire

//--- test/serial_peer_model.sv
// remote serial device: free running bit clock, frame sender, frame monitor
// assumes the transmit line is steady at each baud fall
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
  input wire logic clk_sys,
  input wire logic txdOut,
  output wire logic baudClk,
  output logic rxdIn
);
  // ----------------------------------------
  // bit clock and monitor
  // ----------------------------------------
  logic [2:0] div = 3'h0; // eight clocks a bit; runs free so idle time is counted
  logic [7:0] got = 8'h0; // last byte seen on the transmit line
  logic gotPar = 1'b0; // its parity bit
  logic parOn = 1'b1; // frames carry a parity bit
  int bitN = 0; // place in a frame, 0 while idle
  int gap = 0; // high bits since the last stop bit
  int gapSeen = 0; // gap before the latest start bit
  int frames = 0; // frames finished
  assign baudClk = div[2];
  initial rxdIn = 1'b1;
  // sample mid bit, at the baud fall
  always @(posedge clk_sys) begin
    div <= div + 3'h1;
    if (div == 3'h7) begin
      if (bitN == 0 && !txdOut) begin
        bitN <= 1;
        gapSeen <= gap;
      end else if (bitN == 0) begin
        gap <= gap + 1;
      end else if (bitN <= 8) begin
        got[bitN - 1] <= txdOut;
        bitN <= bitN + 1;
      end else if (bitN == 9 && parOn) begin
        gotPar <= txdOut;
        bitN <= 10;
      end else begin
        bitN <= 0;
        gap <= 0;
        frames <= frames + 1;
      end
    end
  end
  // bits change at a baud fall so they are steady at the sampling rise; last bit high
  task automatic sendBits(input logic [10:0] b);
    for (int i = 0; i < 11; i++) begin
      do @(posedge clk_sys); while (div != 3'h7);
      rxdIn <= b[i];
    end
  endtask : sendBits
endmodule : serial_peer_model
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the serial character unit
// assumes the peer model supplies the bit clock and receive line
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wbAdr = 8'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbAck, baudClk, rxdIn, txdOut, timeoutIrq;
  logic [31:0] wbDatR;
  logic [31:0] rv; // last read data
  logic [7:0] d; // current character
  logic p; // parity bit sent
  int miscompares = 0;
  int n_tests = 0;
  int nf, t;
  always #5 clk_sys = ~clk_sys;
  serial_char_unit dut_u (.clk_sys(clk_sys), .rst(rst), .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel),
    .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbDatR(wbDatR), .baudClk(baudClk),
    .rxdIn(rxdIn), .txdOut(txdOut), .timeoutIrq(timeoutIrq));
  serial_peer_model peer_u (.clk_sys(clk_sys), .txdOut(txdOut), .baudClk(baudClk), .rxdIn(rxdIn));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic fail_hang();
    miscompares++;
    conclude();
  endtask : fail_hang
  // one classic cycle; a spare clock keeps cyc low between requests
  task automatic xfer(input logic [7:0] a, input logic we = 1'b0, input logic [31:0] dw = 32'h0);
    int n = 0;
    wbAdr <= a;
    wbWe <= we;
    wbDatW <= dw;
    wbSel <= 4'hf;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rv = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20) fail_hang();
    @(posedge clk_sys);
  endtask : xfer
  task automatic poll(input int b);
    int n = 0;
    do begin
      xfer(serial_char_pkg::OFS_STATUS);
      n++;
    end while (rv[b] !== 1'b1 && n < 100);
    if (n >= 100) fail_hang();
  endtask : poll
  task automatic waitFrames(input int n);
    int k = 0;
    while (peer_u.frames < n && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000) fail_hang();
  endtask : waitFrames
  // clocks until the interrupt rises, capped at lim
  task automatic irqWait(input int lim);
    t = 0;
    while (timeoutIrq !== 1'b1 && t < lim) begin
      @(posedge clk_sys);
      t++;
    end
  endtask : irqWait
  function automatic logic parOf(input int k, input logic [7:0] v);
    case (k)
      0: return ^v;
      1: return ~^v;
      3: return 1'b1;
      default: return 1'b0; // space, off and multidrop data
    endcase
  endfunction : parOf
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    xfer(serial_char_pkg::OFS_MODE);
    check("mode reset", rv, 32'h4);
    xfer(serial_char_pkg::OFS_STATUS);
    check("status reset", rv, 32'h12);
    xfer(8'h1c);
    check("unmapped", rv, 32'h0);
    xfer(serial_char_pkg::OFS_COMMAND);
    check("command read", rv, 32'h0);
    xfer(serial_char_pkg::OFS_GUARD, 1'b1, 32'h1ff);
    xfer(serial_char_pkg::OFS_GUARD);
    check("guard width", rv, 32'hff);
    xfer(serial_char_pkg::OFS_GUARD, 1'b1, 32'h0);
    // every parity kind, both directions, right and wrong parity
    for (int k = 0; k < 8; k++) begin
      d = 8'h41 + 8'(k);
      peer_u.parOn = (k != 4 && k != 5);
      xfer(serial_char_pkg::OFS_MODE, 1'b1, 32'(k));
      nf = peer_u.frames;
      xfer(serial_char_pkg::OFS_TX_HOLD, 1'b1, 32'(d));
      waitFrames(nf + 1);
      check("tx data", peer_u.got, d);
      if (peer_u.parOn) check("tx parity", peer_u.gotPar, parOf(k, d));
      if (k >= 6) begin
        xfer(serial_char_pkg::OFS_COMMAND, 1'b1, 32'h2);
        xfer(serial_char_pkg::OFS_TX_HOLD, 1'b1, 32'(d));
        waitFrames(nf + 2);
        check("address parity", peer_u.gotPar, 1'b1);
      end
      for (int w = 0; w < 2; w++) begin
        p = peer_u.parOn ? parOf(k, d) ^ w[0] : 1'b1;
        peer_u.sendBits({1'b1, p, d, 1'b0});
        poll(serial_char_pkg::ST_RX_AVAIL);
        check("rx error", rv[serial_char_pkg::ST_CHECK_ERR], peer_u.parOn & w[0]);
        xfer(serial_char_pkg::OFS_RX_HOLD);
        check("rx data", rv, d);
      end
      xfer(serial_char_pkg::OFS_COMMAND, 1'b1, 32'h1);
      xfer(serial_char_pkg::OFS_STATUS);
      check("error cleared", rv[serial_char_pkg::ST_CHECK_ERR], 1'b0);
    end
    // two characters unread: overrun and overwrite
    // frames below: start low, data lsb first, stop and idle high
    xfer(serial_char_pkg::OFS_MODE, 1'b1, 32'h4);
    peer_u.parOn = 1'b0;
    peer_u.sendBits(11'h6b4);
    peer_u.sendBits(11'h74a);
    poll(serial_char_pkg::ST_OVERRUN);
    xfer(serial_char_pkg::OFS_RX_HOLD);
    check("overwrite", rv, 32'ha5);
    xfer(serial_char_pkg::OFS_COMMAND, 1'b1, 32'h1);
    xfer(serial_char_pkg::OFS_STATUS);
    check("overrun cleared", rv[serial_char_pkg::ST_OVERRUN], 1'b0);
    // guard gap of three bits between back-to-back bytes
    xfer(serial_char_pkg::OFS_GUARD, 1'b1, 32'h3);
    nf = peer_u.frames;
    xfer(serial_char_pkg::OFS_TX_HOLD, 1'b1, 32'h11);
    poll(serial_char_pkg::ST_TX_FREE);
    xfer(serial_char_pkg::OFS_TX_HOLD, 1'b1, 32'h22);
    xfer(serial_char_pkg::OFS_STATUS);
    check("free while waiting", rv[serial_char_pkg::ST_TX_FREE], 1'b0);
    waitFrames(nf + 2);
    xfer(serial_char_pkg::OFS_STATUS);
    check("idle during gap", rv[serial_char_pkg::ST_TX_IDLE], 1'b0);
    check("gap bits", peer_u.gapSeen, 32'h3);
    poll(serial_char_pkg::ST_TX_IDLE);
    // idle time-out: restart, arm, character, disabled
    xfer(serial_char_pkg::OFS_IDLE, 1'b1, 32'h5);
    xfer(serial_char_pkg::OFS_COMMAND, 1'b1, 32'h8);
    irqWait(200);
    check("restart delay", (t >= 32 && t <= 52), 1'b1);
    xfer(serial_char_pkg::OFS_COMMAND, 1'b1, 32'h4);
    irqWait(120);
    check("armed idle", t, 32'd120);
    peer_u.sendBits(11'h666);
    irqWait(200);
    check("frame end delay", (t >= 32 && t <= 60), 1'b1);
    xfer(serial_char_pkg::OFS_STATUS);
    check("timeout flag", rv[serial_char_pkg::ST_TIMEOUT], 1'b1);
    xfer(serial_char_pkg::OFS_RX_HOLD);
    xfer(serial_char_pkg::OFS_IDLE, 1'b1, 32'h0);
    xfer(serial_char_pkg::OFS_COMMAND, 1'b1, 32'h8);
    irqWait(120);
    check("disabled", t, 32'd120);
    conclude();
  end
endmodule : tb
`default_nettype wire
